// ===== logic/brl_params.svh
// Constants for the broadcast rate limiter
`ifndef BRL_PARAMS_SVH
`define BRL_PARAMS_SVH
`define BRL_CLK_HZ          25000000
`define BRL_WINDOW_S        1
`define BRL_WINDOW_CYC      (`BRL_CLK_HZ * `BRL_WINDOW_S)
`define BRL_THR_STEP        10
`define BRL_THR_RST         32'h0000_0000
`define BRL_OFF_MODE        8'h00
`define BRL_OFF_PORT_BASE   8'h10
`define BRL_OFF_PORT_STRIDE 8'h10
`define BRL_SUB_THR         2'h0
`define BRL_SUB_TOTAL       2'h1
`define BRL_SUB_PEAK        2'h2
`define BRL_SUB_SINCE       2'h3
`define BRL_MODE_RST        2'h0
`endif

// ===== logic/brl_pkg.sv
// Types for the broadcast rate limiter
package brl_pkg;
  typedef enum logic [1:0] {
    BRL_MODE_OFF,
    BRL_MODE_BRIDGE,
    BRL_MODE_VLAN,
    BRL_MODE_OTHER
  } brl_mode_e;

  typedef struct packed {
    logic        valid;
    logic        bcast;
  } brl_frame_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } brl_bus_s;
endpackage : brl_pkg

// ===== logic/brl_tick.sv
// Divider making the one-second window pulse
`timescale 1ns/100ps
`include "brl_params.svh"
module brl_tick
  import brl_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = `BRL_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // Window pulse
  output logic      tick_out
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 32'h1;
    if (cnt_r == 32'(WINDOW_CYC - 1)) begin
      cnt_nxt  = 32'h0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;
endmodule : brl_tick

// ===== logic/brl_limiter.sv
// Per-port broadcast storm limiter with statistics
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "brl_params.svh"
// How it works
// - Each port counts broadcast frames per one-second window and drops those past the threshold.
// - Every port has its own threshold register giving frames per second allowed through.
// - Each port keeps a readable running total of received broadcast frames.
// - Each port keeps a readable peak of broadcast frames per second.
// - Each port keeps a readable count of seconds since the peak was recorded.
// - A peak reset for a port zeroes its peak and restarts its time since peak.
// - Limiting acts only when the mode is transparent or VLAN-aware bridging.
module brl_limiter
  import brl_pkg::*;
#(
  parameter int unsigned NPORT      = 4,
  parameter int unsigned CW         = 32,
  parameter int unsigned WINDOW_CYC = `BRL_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  // Register port
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  // Receive side, one frame event per port
  input  wire brl_frame_s [NPORT-1:0] rx_frame_in,
  // Forwarding side
  output logic      [NPORT-1:0] fwd_ok_out,
  output logic      [NPORT-1:0] drop_out
);
  logic             tick;
  logic [1:0]       mode_r;
  logic [1:0]       mode_nxt;
  logic [CW-1:0]    thr_r   [NPORT];
  logic [CW-1:0]    thr_nxt [NPORT];
  logic [CW-1:0]    win_r   [NPORT];
  logic [CW-1:0]    win_nxt [NPORT];
  logic [CW-1:0]    tot_r   [NPORT];
  logic [CW-1:0]    tot_nxt [NPORT];
  logic [CW-1:0]    peak_r  [NPORT];
  logic [CW-1:0]    peak_nxt[NPORT];
  logic [CW-1:0]    since_r [NPORT];
  logic [CW-1:0]    since_nxt[NPORT];
  logic [NPORT-1:0] fwd_r;
  logic [NPORT-1:0] fwd_nxt;
  logic [NPORT-1:0] drop_r;
  logic [NPORT-1:0] drop_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic             limit_on;

  brl_tick #(
    .WINDOW_CYC (WINDOW_CYC)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .tick_out    (tick)
  );

  // Port index of a per-port register address
  function automatic int unsigned port_of(input logic [7:0] a);
    return int'((a - `BRL_OFF_PORT_BASE) >> 4);
  endfunction : port_of

  function automatic logic is_port(input logic [7:0] a, input logic [1:0] sub);
    logic [7:0] rel;
    rel = a - `BRL_OFF_PORT_BASE;
    return (a >= `BRL_OFF_PORT_BASE) && (int'(rel >> 4) < NPORT)
           && (rel[3:2] == sub) && (rel[1:0] == 2'h0);
  endfunction : is_port

  assign limit_on = (mode_r == 2'(BRL_MODE_BRIDGE)) || (mode_r == 2'(BRL_MODE_VLAN));

  always_comb begin
    mode_nxt  = mode_r;
    fwd_nxt   = '0;
    drop_nxt  = '0;
    rdata_nxt = 32'h0;
    if (reg_wr_in && reg_addr_in == `BRL_OFF_MODE) begin
      mode_nxt = reg_wdata_in[1:0];
    end
    for (int p = 0; p < NPORT; p++) begin
      thr_nxt[p]   = thr_r[p];
      win_nxt[p]   = win_r[p];
      tot_nxt[p]   = tot_r[p];
      peak_nxt[p]  = peak_r[p];
      since_nxt[p] = since_r[p];
      if (reg_wr_in && is_port(reg_addr_in, `BRL_SUB_THR) && port_of(reg_addr_in) == p) begin
        thr_nxt[p] = reg_wdata_in[CW-1:0];
      end
      if (rx_frame_in[p].valid && !rx_frame_in[p].bcast) begin
        fwd_nxt[p] = 1'b1;
      end
      if (rx_frame_in[p].valid && rx_frame_in[p].bcast) begin
        tot_nxt[p] = tot_r[p] + 1'b1;
        if (limit_on && win_r[p] >= thr_r[p]) begin
          drop_nxt[p] = 1'b1;
        end else begin
          fwd_nxt[p] = 1'b1;
        end
        // Saturate so a long storm cannot wrap and reopen the gate
        if (win_r[p] != '1) begin
          win_nxt[p] = win_r[p] + 1'b1;
        end
      end
      // A frame in the tick cycle is lost with the old window
      if (tick) begin
        win_nxt[p]   = '0;
        since_nxt[p] = since_r[p] + 1'b1;
        if (win_r[p] > peak_r[p]) begin
          peak_nxt[p]  = win_r[p];
          since_nxt[p] = '0;
        end
      end
      // Software clear beats a same-cycle window update
      if (reg_wr_in && is_port(reg_addr_in, `BRL_SUB_PEAK) && port_of(reg_addr_in) == p
          && reg_wdata_in[0]) begin
        peak_nxt[p]  = '0;
        since_nxt[p] = '0;
      end
      if (reg_rd_in && port_of(reg_addr_in) == p) begin
        if (is_port(reg_addr_in, `BRL_SUB_THR)) rdata_nxt = 32'(thr_r[p]);
        if (is_port(reg_addr_in, `BRL_SUB_TOTAL)) rdata_nxt = 32'(tot_r[p]);
        if (is_port(reg_addr_in, `BRL_SUB_PEAK)) rdata_nxt = 32'(peak_r[p]);
        if (is_port(reg_addr_in, `BRL_SUB_SINCE)) rdata_nxt = 32'(since_r[p]);
      end
    end
    if (reg_rd_in && reg_addr_in == `BRL_OFF_MODE) begin
      rdata_nxt = {30'h0, mode_r};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r  <= `BRL_MODE_RST;
      fwd_r   <= '0;
      drop_r  <= '0;
      rdata_r <= 32'h0;
      for (int p = 0; p < NPORT; p++) begin
        thr_r[p]   <= CW'(`BRL_THR_RST);
        win_r[p]   <= '0;
        tot_r[p]   <= '0;
        peak_r[p]  <= '0;
        since_r[p] <= '0;
      end
    end else begin
      mode_r  <= mode_nxt;
      fwd_r   <= fwd_nxt;
      drop_r  <= drop_nxt;
      rdata_r <= rdata_nxt;
      for (int p = 0; p < NPORT; p++) begin
        thr_r[p]   <= thr_nxt[p];
        win_r[p]   <= win_nxt[p];
        tot_r[p]   <= tot_nxt[p];
        peak_r[p]  <= peak_nxt[p];
        since_r[p] <= since_nxt[p];
      end
    end
  end

  assign reg_rdata_out = rdata_r;
  assign fwd_ok_out    = fwd_r;
  assign drop_out      = drop_r;

  // Port 0 stands for all ports except in a_drop_needs_mode, which checks every port; each runs the same logic
  a_drop_needs_mode: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    |drop_r |-> $past(limit_on)) else $error("Drop outside bridging mode");
  a_drop_over_thr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    drop_r[0] |-> $past(win_r[0]) >= $past(thr_r[0])) else $error("Drop below threshold");
  a_fwd_under_thr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_frame_in[0].valid && rx_frame_in[0].bcast && win_r[0] < thr_r[0]
    |=> fwd_r[0] && !drop_r[0]) else $error("Frame under threshold dropped");
  a_thr_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == `BRL_OFF_PORT_BASE
    |=> thr_r[0] == $past(reg_wdata_in[CW-1:0])) else $error("Threshold not stored");
  a_total_counts: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_frame_in[0].valid && rx_frame_in[0].bcast |=> tot_r[0] == $past(tot_r[0]) + 1'b1)
    else $error("Total missed a frame");
  a_peak_rises: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick && win_r[0] > peak_r[0] && !reg_wr_in |=> peak_r[0] == $past(win_r[0]) && since_r[0] == '0)
    else $error("Peak not taken");
  a_peak_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !tick && !reg_wr_in |=> $stable(peak_r[0])) else $error("Peak moved between windows");
  a_since_steps: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick && win_r[0] <= peak_r[0] && !reg_wr_in |=> since_r[0] == $past(since_r[0]) + 1'b1)
    else $error("Time since peak not advanced");
  a_peak_reset: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == (`BRL_OFF_PORT_BASE + 8'h08) && reg_wdata_in[0]
    |=> peak_r[0] == '0 && since_r[0] == '0) else $error("Peak reset ignored");
  a_window_clears: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    tick |=> win_r[0] == '0) else $error("Window count not cleared");
  a_bcast_answers: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_frame_in[0].valid && rx_frame_in[0].bcast |=> fwd_r[0] != drop_r[0])
    else $error("Broadcast frame not answered once");
  a_ucast_passes: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_frame_in[0].valid && !rx_frame_in[0].bcast |=> fwd_r[0] && !drop_r[0])
    else $error("Non-broadcast frame held back");
  a_off_mode_passes: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rx_frame_in[0].valid && rx_frame_in[0].bcast && !limit_on |=> fwd_r[0] && !drop_r[0])
    else $error("Frame dropped outside bridging mode");
  a_thr_own_port: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    reg_wr_in && reg_addr_in == (`BRL_OFF_PORT_BASE + `BRL_OFF_PORT_STRIDE)
    |=> $stable(thr_r[0])) else $error("Threshold write reached another port");
  a_total_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == (`BRL_OFF_PORT_BASE + 8'h04)
    |=> reg_rdata_out == 32'($past(tot_r[0]))) else $error("Total read wrong");
  a_peak_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == (`BRL_OFF_PORT_BASE + 8'h08)
    |=> reg_rdata_out == 32'($past(peak_r[0]))) else $error("Peak read wrong");
  a_since_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == (`BRL_OFF_PORT_BASE + 8'h0c)
    |=> reg_rdata_out == 32'($past(since_r[0]))) else $error("Time since peak read wrong");
  a_since_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !tick && !reg_wr_in |=> $stable(since_r[0])) else $error("Time since peak moved early");
  a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !reg_rd_in |=> reg_rdata_out == 32'h0) else $error("Read data left standing");
endmodule : brl_limiter

// ===== dv/brl_rx_src.sv
// Frame source standing in for the port receive paths
`timescale 1ns/100ps
module brl_rx_src
  import brl_pkg::*;
#(
  parameter int unsigned NPORT = 4
) (
  // Clock
  input  wire logic              core_clk_in,
  // Frame events
  output brl_frame_s [NPORT-1:0] rx_frame_out
);
  initial rx_frame_out = '0;
  // Back-to-back frames on one port, broadcast unless told otherwise
  task automatic send(input int port, input int n, input logic bc = 1'b1);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_in);
      rx_frame_out[port] <= {1'b1, bc};
    end
    @(posedge core_clk_in);
    rx_frame_out[port] <= 2'b00;
  endtask : send
endmodule : brl_rx_src

// ===== dv/tb_brl_limiter.sv
// Testbench for the broadcast rate limiter
`timescale 1ns/100ps
module tb_brl_limiter
  import brl_pkg::*;
;
  localparam int unsigned WIN = 400;
  logic             core_clk_in  = 1'b0;
  logic             rst_n_in     = 1'b0;
  logic [7:0]       reg_addr_in  = 8'h00;
  logic [31:0]      reg_wdata_in = 32'h0;
  logic             reg_wr_in    = 1'b0;
  logic             reg_rd_in    = 1'b0;
  logic [31:0]      reg_rdata_out;
  logic [31:0]      d;
  brl_frame_s [3:0] rx_frame;
  logic [3:0]       fwd_ok_out;
  logic [3:0]       drop_out;
  int               num_errors = 0;
  int               compares   = 0;
  int               cyc        = 0;
  int               nfwd[2]    = '{0, 0};
  int               ndrop[2]   = '{0, 0};

  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    for (int p = 0; p < 2; p++) begin
      // Unknown pulses count as missing
      nfwd[p] += int'(fwd_ok_out[p] === 1'b1);
      ndrop[p] += int'(drop_out[p] === 1'b1);
    end
  end

  brl_rx_src #(.NPORT(4)) src (.core_clk_in(core_clk_in), .rx_frame_out(rx_frame));
  brl_limiter #(.NPORT(4), .CW(32), .WINDOW_CYC(WIN)) dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rx_frame_in(rx_frame), .fwd_ok_out(fwd_ok_out),
    .drop_out(drop_out));

  function automatic logic [7:0] pa(input int p, input int s);
    return 8'((16 + 16 * p) + 4 * s);
  endfunction : pa

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Read strobe one cycle, data sampled in the following cycle
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    chk(d, e);
  endtask : rc

  task automatic burst(input int n, input logic bc, input int exp_fwd, input int exp_drop);
    nfwd[0] = 0;
    ndrop[0] = 0;
    src.send(0, n, bc);
    repeat (3) @(posedge core_clk_in);
    chk(nfwd[0], exp_fwd);
    chk(ndrop[0], exp_drop);
  endtask : burst

  task automatic wait_until(input int n);
    while (cyc < n) @(posedge core_clk_in);
  endtask : wait_until

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rc(8'h00, 32'h0);
    rc(pa(0, 0), 32'h0);
    rc(pa(0, 1), 32'h0);
    rc(8'hf0, 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'h1);
    wr(pa(0, 0), 32'd10);
    wr(pa(1, 0), 32'd20);
    fork
      burst(15, 1'b1, 10, 5);
      src.send(1, 15);
    join
    chk(nfwd[1], 15);
    chk(ndrop[1], 0);
    rc(pa(0, 1), 32'd15);
    $display("test threshold limit done");
    wait_until(2 * WIN + 200);
    rc(pa(0, 2), 32'd15);
    rc(pa(0, 3), 32'd1);
    rc(pa(1, 2), 32'd15);
    wr(8'hf0, 32'h5);
    rc(8'hf0, 32'h0);
    $display("test peak tracking done");
    wr(pa(0, 2), 32'h1);
    rc(pa(0, 2), 32'h0);
    rc(pa(0, 3), 32'h0);
    rc(pa(1, 2), 32'd15);
    $display("test peak reset done");
    wr(8'h00, 32'h3);
    burst(15, 1'b1, 15, 0);
    wait_until(3 * WIN + 20);
    rc(pa(0, 2), 32'd15);
    rc(pa(0, 3), 32'h0);
    rc(pa(1, 3), 32'd2);
    wr(8'h00, 32'h2);
    burst(15, 1'b1, 10, 5);
    burst(5, 1'b0, 5, 0);
    rc(pa(0, 1), 32'd45);
    wr(8'h00, 32'h0);
    burst(15, 1'b1, 15, 0);
    rc(pa(0, 1), 32'd60);
    $display("test modes done");
    print_verdict();
  end
endmodule : tb_brl_limiter
